// ### src/smbst_pkg.sv
package smbst_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] SMBST_STATUS_OFS = 12'h424;
    localparam logic [11:0] SMBST_CTRL_OFS = 12'h428;
    localparam logic [11:0] SMBST_IMASK_OFS = 12'h430;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int SMBST_SADDR_LSB = 1;
    localparam int SMBST_MADDR_LSB = 9;
    localparam int SMBST_DONE_BIT = 24;
    localparam int SMBST_ERR_LSB = 25;
    localparam int SMBST_CTRL_IOM_BIT = 16;
    localparam int SMBST_CTRL_ICS_BIT = 17;

    // ----------------------------------------
    // Reset values and counts
    // ----------------------------------------
    localparam logic [4:0] SMBST_ERR_RST = 5'h00;
    localparam logic [4:0] SMBST_MASK_RST = 5'h00;
    localparam int SMBST_ARB_LIMIT = 16;

    typedef enum logic [1:0] {
        SMBST_IDLE = 2'b00,
        SMBST_ARB = 2'b01,
        SMBST_XFER = 2'b10
    } smbst_arb_state_t;

    // Events reported by the master SMBus engine and the EEPROM loader.
    typedef struct packed {
        logic arb_start;
        logic arb_won;
        logic arb_lost;
        logic xfer_done;
        logic nack;
        logic misplaced_cond;
    } smbst_master_ev_t;

    typedef struct packed {
        logic load_enabled;
        logic load_end;
        logic done_cmd_seen;
        logic checksum_bad;
        logic unmapped_write;
    } smbst_loader_ev_t;

endpackage

// ### src/smbst_status.sv
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module smbst_status
#(
    // Straight arbitration losses that end a transfer
    parameter int ARB_LIMIT = smbst_pkg::SMBST_ARB_LIMIT
)
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Hardware initialised addresses
    input wire logic [6:0] slave_port_address,
    input wire logic [6:0] master_port_address,
    // Master engine and loader events
    input wire smbst_pkg::smbst_master_ev_t mst_ev,
    input wire smbst_pkg::smbst_loader_ev_t ldr_ev,
    // Master engine control
    output logic arb_retry,
    output logic xfer_abort,
    output logic xfer_proceed,
    // Interrupt
    output logic irq
);
    import smbst_pkg::*;

    // ----------------------------------------
    // Parameter checks
    // ----------------------------------------
    // The loss counter is five bits wide, so it cannot count past thirty-one.
    generate
        if (ARB_LIMIT < 2 || ARB_LIMIT > 32)
        begin : g_bad_limit
            $error("ARB_LIMIT out of range");
        end
    endgenerate

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
        return addr == ofs;
    endfunction

    function automatic logic reg_known(input logic [11:0] addr);
        return reg_hit(addr, SMBST_STATUS_OFS) || reg_hit(addr, SMBST_CTRL_OFS) ||
               reg_hit(addr, SMBST_IMASK_OFS);
    endfunction

    // Places the five error bits at their field; the mask shares the layout.
    function automatic logic [31:0] err_word(input logic [4:0] err);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SMBST_ERR_LSB +: 5] = err;
        return w;
    endfunction

    function automatic logic [31:0] status_word(
        input logic [6:0] saddr,
        input logic [6:0] maddr,
        input logic done,
        input logic [4:0] err
    );
        logic [31:0] w;
        w = err_word(err);
        w[SMBST_SADDR_LSB +: 7] = saddr;
        w[SMBST_MADDR_LSB +: 7] = maddr;
        w[SMBST_DONE_BIT] = done;
        return w;
    endfunction

    function automatic logic [31:0] ctrl_word(input logic iom, input logic ics);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[SMBST_CTRL_IOM_BIT] = iom;
        w[SMBST_CTRL_ICS_BIT] = ics;
        return w;
    endfunction

    // ----------------------------------------
    // Register access
    // ----------------------------------------
    logic wr_en;
    logic rd_en;
    logic [6:0] saddr_r;
    logic [6:0] maddr_r;
    logic addr_cap_r;
    logic done_r;
    logic [4:0] err_r;
    logic [4:0] err_nxt;
    logic [4:0] err_set;
    logic [4:0] mask_r;
    logic iom_r;
    logic ics_r;
    logic [4:0] lost_cnt_r;
    smbst_arb_state_t st_r;
    logic wr_status;
    logic wr_ctrl;
    logic wr_mask;
    logic [31:0] rd_word;
    logic [4:0] lost_limit;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !pwrite;
    assign pready = 1'b1;
    assign wr_status = wr_en && reg_hit(paddr, SMBST_STATUS_OFS);
    assign wr_ctrl = wr_en && reg_hit(paddr, SMBST_CTRL_OFS);
    assign wr_mask = wr_en && reg_hit(paddr, SMBST_IMASK_OFS);
    assign lost_limit = 5'(ARB_LIMIT - 1);

    // Unmapped addresses answer with an error so stray software is visible.
    always_comb
    begin
        pslverr = 1'b0;
        if (psel && penable)
        begin
            pslverr = !reg_known(paddr);
        end
    end

    // Address capture once after reset release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            saddr_r <= 7'h00;
            maddr_r <= 7'h00;
            addr_cap_r <= 1'b0;
        end
        else if (!addr_cap_r)
        begin
            saddr_r <= slave_port_address;
            maddr_r <= master_port_address;
            addr_cap_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    // Reserved bits and unmapped offsets read as zero.
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (paddr)
            SMBST_STATUS_OFS:
            begin
                rd_word = status_word(saddr_r, maddr_r, done_r, err_r);
            end
            SMBST_CTRL_OFS:
            begin
                rd_word = ctrl_word(iom_r, ics_r);
            end
            SMBST_IMASK_OFS:
            begin
                rd_word = err_word(mask_r);
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // Read data is taken in the setup cycle so it stands through the access phase.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (rd_en && !penable)
        begin
            prdata <= rd_word;
        end
    end

    // ----------------------------------------
    // Control and mask registers
    // ----------------------------------------
    // Override controls from software.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            iom_r <= 1'b0;
            ics_r <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            iom_r <= pwdata[SMBST_CTRL_IOM_BIT];
            ics_r <= pwdata[SMBST_CTRL_ICS_BIT];
        end
    end

    // A set mask bit lets its error flag raise the interrupt.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_r <= SMBST_MASK_RST;
        end
        else if (wr_mask)
        begin
            mask_r <= pwdata[SMBST_ERR_LSB +: 5];
        end
    end

    // ----------------------------------------
    // Arbitration retry
    // ----------------------------------------
    // Automatic re-arbitration pulse.
    assign arb_retry = (st_r == SMBST_ARB) && mst_ev.arb_lost && !iom_r &&
                       (lost_cnt_r != lost_limit);
    assign xfer_abort = (st_r == SMBST_ARB) && mst_ev.arb_lost && !iom_r &&
                        (lost_cnt_r == lost_limit);
    assign xfer_proceed = (st_r == SMBST_ARB) &&
                          (mst_ev.arb_won || (mst_ev.arb_lost && iom_r));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= SMBST_IDLE;
            lost_cnt_r <= 5'h00;
        end
        else
        begin
            unique case (st_r)
                SMBST_IDLE:
                begin
                    lost_cnt_r <= 5'h00;
                    if (mst_ev.arb_start)
                    begin
                        st_r <= SMBST_ARB;
                    end
                end
                SMBST_ARB:
                begin
                    if (xfer_proceed)
                    begin
                        st_r <= SMBST_XFER;
                    end
                    else if (xfer_abort)
                    begin
                        st_r <= SMBST_IDLE;
                    end
                    else if (arb_retry)
                    begin
                        lost_cnt_r <= lost_cnt_r + 5'h01;
                    end
                end
                SMBST_XFER:
                begin
                    if (mst_ev.xfer_done)
                    begin
                        st_r <= SMBST_IDLE;
                    end
                end
                default: st_r <= SMBST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    always_comb
    begin
        err_set = 5'h00;
        err_set[0] = mst_ev.nack;
        err_set[1] = xfer_abort;
        err_set[2] = mst_ev.misplaced_cond;
        err_set[3] = ldr_ev.load_enabled && !ics_r &&
                     (ldr_ev.checksum_bad || (ldr_ev.load_end && !ldr_ev.done_cmd_seen));
        err_set[4] = ldr_ev.load_enabled && ldr_ev.unmapped_write;
        err_nxt = err_r;
        if (wr_status)
        begin
            err_nxt = err_r & ~pwdata[SMBST_ERR_LSB +: 5];
        end
        err_nxt = err_nxt | err_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            err_r <= SMBST_ERR_RST;
        end
        else
        begin
            err_r <= err_nxt;
        end
    end

    // Loader done on end or error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_r <= 1'b0;
        end
        else if (ldr_ev.load_enabled && (ldr_ev.load_end || err_set[3] ||
                 ldr_ev.checksum_bad || ldr_ev.unmapped_write))
        begin
            done_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    // Decoded from the err_r and mask_r flip-flops; irq itself is not registered.
    assign irq = |(err_r & mask_r);

endmodule

// ### tb/smbst_chk.sv
`timescale 1ns/10ps
module smbst_chk
(
    // Bus side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Engine side
    input wire logic [6:0] slave_port_address,
    input wire logic [6:0] master_port_address,
    input wire smbst_pkg::smbst_master_ev_t mst_ev,
    input wire smbst_pkg::smbst_loader_ev_t ldr_ev,
    input wire logic arb_retry,
    input wire logic xfer_abort,
    input wire logic xfer_proceed,
    input wire logic irq
);
    import smbst_pkg::*;
    // --------
    // Checks
    // --------
    logic [4:0] lost_r;
    logic wr;
    logic cause;
    assign wr = psel && penable && pwrite;
    assign cause = wr || xfer_abort || mst_ev.nack || mst_ev.misplaced_cond
        || ldr_ev.load_end || ldr_ev.checksum_bad || ldr_ev.unmapped_write;
    // Straight losses, so the abort point is judged apart from the design.
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            lost_r <= 5'h00;
        else if (mst_ev.arb_start || mst_ev.arb_won || xfer_abort)
            lost_r <= 5'h00;
        else if (mst_ev.arb_lost)
            lost_r <= lost_r + 5'h01;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_rd_status;
        psel && penable && !pwrite && paddr == SMBST_STATUS_OFS;
    endsequence
    chk_zero_wait: assert property (psel && penable |-> pready) else $error("wait");
    chk_addr_read: assert property (s_rd_status |->
        prdata[15:0] == {master_port_address, 1'b0, slave_port_address, 1'b0})
        else $error("address field");
    chk_lost_answer: assert property (mst_ev.arb_lost |->
        $onehot({arb_retry, xfer_abort, xfer_proceed})) else $error("loss answer");
    chk_answer_cause: assert property (arb_retry || xfer_abort |->
        mst_ev.arb_lost) else $error("answer cause");
    chk_abort_count: assert property (xfer_abort |-> lost_r == 5'h0f)
        else $error("abort early");
    chk_abort_due: assert property (mst_ev.arb_lost && lost_r == 5'h0f
        && !xfer_proceed |-> xfer_abort) else $error("abort late");
    chk_won_go: assert property (mst_ev.arb_won |-> xfer_proceed)
        else $error("won");
    chk_irq_cause: assert property ($rose(irq) |-> $past(cause))
        else $error("irq cause");
    chk_irq_clear: assert property ($fell(irq) |-> $past(wr))
        else $error("irq clear");
endmodule
bind smbst_status smbst_chk i_smbst_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .slave_port_address, .master_port_address,
    .mst_ev, .ldr_ev, .arb_retry, .xfer_abort, .xfer_proceed, .irq);

// ### tb/smbst_far.sv
`timescale 1ns/10ps
module smbst_far
(
    // Events toward the block
    input wire logic pclk,
    output smbst_pkg::smbst_master_ev_t mst_ev,
    output smbst_pkg::smbst_loader_ev_t ldr_ev
);
    import smbst_pkg::*;
    initial
    begin
        mst_ev = '0;
        ldr_ev = '0;
    end
    // Pulses last one cycle; the loader levels are kept afterwards.
    task automatic fire(input logic [5:0] m, input logic [4:0] l);
        @(posedge pclk);
        mst_ev <= m;
        ldr_ev <= l;
        @(posedge pclk);
        mst_ev <= '0;
        ldr_ev <= l & 5'h14;
    endtask
    // Losses, then a win or giving up.
    task automatic arb(input int lost, input logic won);
        fire(6'h20, ldr_ev);
        repeat (lost) fire(6'h08, ldr_ev);
        if (won)
            fire(6'h10, ldr_ev);
        fire(6'h04, ldr_ev);
    endtask
endmodule

// ### tb/smbus_master_status_test.sv
`timescale 1ns/10ps
module smbus_master_status_test;
    import smbst_pkg::*;
    // --------
    // Bench
    // --------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic pready;
    logic pslverr;
    logic rerr;
    logic irq;
    smbst_master_ev_t mst_ev;
    smbst_loader_ev_t ldr_ev;
    int bad_count = 0;
    int check_count = 0;
    logic [42:0] rows [6] = '{{6'h02, 5'h00, 32'h0200a254}, {6'h01, 5'h00, 32'h0800a254},
        {6'h00, 5'h1c, 32'h0100a254}, {6'h00, 5'h12, 32'h1100a254},
        {6'h00, 5'h11, 32'h2100a254}, {6'h00, 5'h18, 32'h1100a254}};
    always #20 pclk = ~pclk;
    smbst_status i_smbst_status (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .slave_port_address(7'h2a),
        .master_port_address(7'h51), .mst_ev, .ldr_ev, .arb_retry(), .xfer_abort(),
        .xfer_proceed(), .irq);
    smbst_far i_smbst_far (.pclk, .mst_ev, .ldr_ev);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d bad %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            bad_count++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdat, exp);
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd(12'h424, 32'h0000a254);
        rd(12'h428, 32'h0);
        rd(12'h430, 32'h0);
        rd(12'h42c, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        foreach (rows[i])
        begin
            i_smbst_far.fire(rows[i][42:37], rows[i][36:32]);
            apb(1'b1, 12'h424, 32'h0);
            rd(12'h424, rows[i][31:0]);
            apb(1'b1, 12'h424, 32'h3e000000);
            rd(12'h424, rows[i][31:0] & 32'hc1ffffff);
        end
        i_smbst_far.arb(15, 1'b1);
        rd(12'h424, 32'h0100a254);
        i_smbst_far.arb(16, 1'b0);
        rd(12'h424, 32'h0500a254);
        apb(1'b1, 12'h424, 32'h04000000);
        apb(1'b1, 12'h428, 32'h00010000);
        i_smbst_far.arb(1, 1'b0);
        rd(12'h424, 32'h0100a254);
        apb(1'b1, 12'h428, 32'h00020000);
        i_smbst_far.fire(6'h00, 5'h12);
        i_smbst_far.fire(6'h00, 5'h18);
        rd(12'h424, 32'h0100a254);
        apb(1'b1, 12'h430, 32'h02000000);
        i_smbst_far.fire(6'h02, 5'h10);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h424, 32'h02000000);
        @(negedge pclk);
        chk({31'h0, irq}, 32'h0);
        // A flag set and cleared at the same edge must stay set.
        fork
            apb(1'b1, 12'h424, 32'h02000000);
            begin
                @(posedge pclk);
                i_smbst_far.fire(6'h02, 5'h10);
            end
        join
        rd(12'h424, 32'h0300a254);
        print_verdict();
    end
endmodule
